/* design/bbce_pkg.sv */
// Package: register map, field layouts, cost table and types of the bit-branch execution unit
package bbce_pkg;

    // Register byte offsets
    localparam logic [7:0]  BBCE_OFF_INSN   = 8'h00;
    localparam logic [7:0]  BBCE_OFF_PC     = 8'h04;
    localparam logic [7:0]  BBCE_OFF_DATA   = 8'h08;
    localparam logic [7:0]  BBCE_OFF_CLKSEL = 8'h0C;
    localparam logic [7:0]  BBCE_OFF_CMD    = 8'h10;
    localparam logic [7:0]  BBCE_OFF_STATUS = 8'h14;

    // Writable bits of the instruction register, then reset values; masked bits read as zero
    localparam logic [23:0] BBCE_INSN_MASK  = 24'hFF0FF7;
    localparam logic [2:0]  BBCE_CLKSEL_RST = 3'h0;
    localparam logic [15:0] BBCE_PC_RST     = 16'h0000;
    localparam logic [7:0]  BBCE_BYTE_RST   = 8'h00;

    // Command bits and status layout
    localparam int          BBCE_CMD_START  = 0;
    localparam int          BBCE_CMD_WAKE   = 1;
    localparam int          BBCE_ST_LEN_LSB = 8;
    localparam int          BBCE_ST_CYC_LSB = 16;

    // Extra fetch cycles when code does not come from the internal program ROM
    localparam logic [4:0]  BBCE_FETCH_WAIT = 5'h02;

    localparam logic [1:0]  BBCE_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  BBCE_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_BIT_SET   = 3'h0,    // branch_if_bit_set
        OP_BIT_CLEAR = 3'h1,    // branch_if_bit_clear
        OP_BIT_TCLR  = 3'h2,    // branch_and_clear_if_set
        OP_DEC_BNZ   = 3'h3,    // decrement_branch_nonzero
        OP_UNMASK    = 3'h4,    // unmask_interrupts_op
        OP_MASK      = 3'h5,    // mask_all_interrupts_op
        OP_HALT      = 3'h6,
        OP_STOP      = 3'h7
    } bbce_op_t;

    typedef enum logic [2:0] {
        MD_SADDR = 3'h0,
        MD_SFR   = 3'h1,
        MD_ACC   = 3'h2,
        MD_PSW   = 3'h3,
        MD_HL    = 3'h4,
        MD_REG_B = 3'h5,
        MD_REG_C = 3'h6
    } bbce_mode_t;

    typedef struct packed {
        logic [7:0] disp;       // relative_offset_byte
        logic [3:0] rsvd_hi;
        logic       ext_fetch;
        logic       ext_area;
        logic [2:0] bitn;
        bbce_mode_t mode;
        logic       rsvd_lo;
        bbce_op_t   op;
    } bbce_insn_t;

    // Length and the two cycle counts; a zero count means that column does not exist
    typedef struct packed {
        logic [2:0] len;
        logic [4:0] c1;
        logic [4:0] c2;
    } bbce_row_t;

    typedef struct packed {
        logic       legal;
        logic [2:0] len;
        logic [4:0] cyc;
    } bbce_cost_t;

    localparam bbce_row_t ROW_SET_SADDR = '{len: 3'h3, c1: 5'h08, c2: 5'h09};
    localparam bbce_row_t ROW_SFR_TEST  = '{len: 3'h4, c1: 5'h00, c2: 5'h0B};
    localparam bbce_row_t ROW_ACC       = '{len: 3'h3, c1: 5'h08, c2: 5'h00};
    localparam bbce_row_t ROW_SET_PSW   = '{len: 3'h3, c1: 5'h00, c2: 5'h09};
    localparam bbce_row_t ROW_HL_TEST   = '{len: 3'h3, c1: 5'h0A, c2: 5'h0B};
    localparam bbce_row_t ROW_CLR_SADDR = '{len: 3'h4, c1: 5'h0A, c2: 5'h0B};
    localparam bbce_row_t ROW_CLR_PSW   = '{len: 3'h4, c1: 5'h00, c2: 5'h0B};
    localparam bbce_row_t ROW_TC_SADDR  = '{len: 3'h4, c1: 5'h0A, c2: 5'h0C};
    localparam bbce_row_t ROW_TC_SFR    = '{len: 3'h4, c1: 5'h00, c2: 5'h0C};
    localparam bbce_row_t ROW_TC_HL     = '{len: 3'h3, c1: 5'h0A, c2: 5'h0C};
    localparam bbce_row_t ROW_DECREMENT_BRANCH_NONZERO_REG  = '{len: 3'h2, c1: 5'h06, c2: 5'h00};
    localparam bbce_row_t ROW_DECREMENT_BRANCH_NONZERO_SAD  = '{len: 3'h3, c1: 5'h08, c2: 5'h0A};
    localparam bbce_row_t ROW_IRQ_CTL   = '{len: 3'h2, c1: 5'h00, c2: 5'h06};
    localparam bbce_row_t ROW_STANDBY   = '{len: 3'h2, c1: 5'h06, c2: 5'h00};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01
    } bbce_fsm_t;

    typedef struct packed {
        logic [6:0] cnt;
    } bbce_div_t;

    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [23:0] insn;
        logic [15:0] pc;
        logic [7:0]  opnd;
        logic [7:0]  program_status_word;       // program_status_word
        logic [2:0]  clksel;    // processor_clock_select_reg
        bbce_fsm_t   st;
        logic [4:0]  cnt;
        logic        ie;        // global_irq_allow
        logic        halt;
        logic        stop;
        logic        done;
        logic        taken;
        logic        err;
        logic [4:0]  chk_ticks;
    } bbce_state_t;

endpackage

/* design/bbce_fdiv.sv */
// Core clock enable divider: one tick per selected core clock period
`timescale 1ns/100ps
`default_nettype none
module bbce_fdiv
    import bbce_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [2:0] sel,
    input  wire logic       clr,
    input  wire logic       run,
    output logic            tick
);
    bbce_div_t  q;
    bbce_div_t  d;
    logic [6:0] mask;

    // Period is 2^sel core clocks
    assign mask = 7'(((8'h01 << sel) - 8'h01));
    // Compare with >= so a shorter period chosen mid-count still ticks at once
    assign tick = run && !clr && (q.cnt >= mask);

    always_comb begin
        d = q;
        if (clr) begin
            d.cnt = 7'h00;
        end else if (run) begin
            d.cnt = tick ? 7'h00 : 7'(q.cnt + 7'h01);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* design/bbce_cost.sv */
// Instruction length and cycle cost lookup
`timescale 1ns/100ps
`default_nettype none
module bbce_cost
    import bbce_pkg::*;
(
    input  wire bbce_op_t   op,
    input  wire bbce_mode_t mode,
    input  wire logic       ext_area,
    input  wire logic       ext_fetch,
    output bbce_cost_t      cost
);
    bbce_row_t row;
    logic      ok;
    logic [4:0] base;

    always_comb begin
        row = ROW_ACC;
        ok  = 1'b1;
        case (op)
            OP_BIT_SET: begin
                case (mode)
                    MD_SADDR: row = ROW_SET_SADDR;
                    MD_SFR:   row = ROW_SFR_TEST;
                    MD_ACC:   row = ROW_ACC;
                    MD_PSW:   row = ROW_SET_PSW;
                    MD_HL:    row = ROW_HL_TEST;
                    default:  ok  = 1'b0;
                endcase
            end
            OP_BIT_CLEAR: begin
                case (mode)
                    MD_SADDR: row = ROW_CLR_SADDR;
                    MD_SFR:   row = ROW_SFR_TEST;
                    MD_ACC:   row = ROW_ACC;
                    MD_PSW:   row = ROW_CLR_PSW;
                    MD_HL:    row = ROW_HL_TEST;
                    default:  ok  = 1'b0;
                endcase
            end
            OP_BIT_TCLR: begin
                case (mode)
                    MD_SADDR: row = ROW_TC_SADDR;
                    MD_SFR:   row = ROW_TC_SFR;
                    MD_ACC:   row = ROW_ACC;
                    MD_PSW:   row = ROW_TC_SFR;
                    MD_HL:    row = ROW_TC_HL;
                    default:  ok  = 1'b0;
                endcase
            end
            OP_DEC_BNZ: begin
                case (mode)
                    MD_REG_B, MD_REG_C: row = ROW_DECREMENT_BRANCH_NONZERO_REG;
                    MD_SADDR: row = ROW_DECREMENT_BRANCH_NONZERO_SAD;
                    default:  ok  = 1'b0;
                endcase
            end
            OP_UNMASK, OP_MASK: row = ROW_IRQ_CTL;
            default: row = ROW_STANDBY;
        endcase
        // Fall back to the only column an addressing form has
        if (row.c1 == 5'h00 || (ext_area && row.c2 != 5'h00)) begin
            base = row.c2;
        end else begin
            base = row.c1;
        end
        cost.legal = ok;
        cost.len   = row.len;
        cost.cyc   = ext_fetch ? 5'(base + BBCE_FETCH_WAIT) : base;
    end
endmodule
`default_nettype wire

/* design/bbce_exec_top.sv */
// Bit-test branch, decrement loop and CPU control execution unit with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bbce_exec_top
    import bbce_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cpu_tick,
    output logic             irq_accept_ok,
    output logic             core_halted,
    output logic             osc_stopped
);
    bbce_state_t q;
    bbce_state_t s;
    bbce_insn_t  ins;
    bbce_cost_t  cost;
    logic        tick;
    logic        start;
    logic        commit;
    logic        do_wr;
    logic [7:0]  src;
    logic        bit_val;
    logic        taken;
    logic [7:0]  new_opnd;
    logic [7:0]  new_psw;
    logic [7:0]  dec_val;
    logic [15:0] chk_seq;
    logic [15:0] chk_off;
    logic [15:0] target;
    logic [31:0] status;

    function automatic logic [31:0] bbce_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    assign ins = bbce_insn_t'(q.insn);

    bbce_cost i_bbce_cost (
        .op        (ins.op),
        .mode      (ins.mode),
        .ext_area  (ins.ext_area),
        .ext_fetch (ins.ext_fetch),
        .cost      (cost)
    );

    // Core clock stands while halted or stopped; the bus side keeps running
    bbce_fdiv i_bbce_fdiv (
        .core_clk (core_clk),
        .rst      (rst),
        .sel      (q.clksel),
        .clr      (start),
        .run      (!q.halt && !q.stop),
        .tick     (tick)
    );

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready  = !q.w_got && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign cpu_tick      = tick;
    assign core_halted   = q.halt;
    assign osc_stopped   = q.stop;
    // No interrupt may slip in while a test-and-clear is in flight
    assign irq_accept_ok = q.ie && !(q.st == ST_RUN && ins.op == OP_BIT_TCLR);

    assign do_wr  = q.aw_got && q.w_got && !q.bvalid;
    assign start  = do_wr && q.awaddr == BBCE_OFF_CMD && q.wstrb[0]
                    && q.wdata[BBCE_CMD_START] && q.st == ST_IDLE
                    && !q.halt && !q.stop && cost.legal;
    assign commit = q.st == ST_RUN && tick && q.cnt == 5'h01;

    assign status = {11'h000, cost.cyc, 5'h00, cost.len, irq_accept_ok, q.err,
                     q.stop, q.halt, q.ie, q.taken, q.done, q.st == ST_RUN};

    // Operation results, computed from the frozen operands
    always_comb begin
        src      = (ins.mode == MD_PSW) ? q.program_status_word : q.opnd;
        bit_val  = src[ins.bitn];
        dec_val  = 8'(q.opnd - 8'h01);
        new_opnd = q.opnd;
        new_psw  = q.program_status_word;
        taken    = 1'b0;
        case (ins.op)
            OP_BIT_SET:   taken = bit_val;
            OP_BIT_CLEAR: taken = !bit_val;
            OP_BIT_TCLR: begin
                taken = bit_val;
                if (bit_val && ins.mode == MD_PSW) begin
                    new_psw[ins.bitn] = 1'b0;
                end else if (bit_val) begin
                    new_opnd[ins.bitn] = 1'b0;
                end
            end
            OP_DEC_BNZ: begin
                new_opnd = dec_val;
                taken    = dec_val != 8'h00;
            end
            default: taken = 1'b0;
        endcase
    end

    assign chk_seq = 16'(q.pc + 16'(cost.len));
    assign chk_off = {{8{ins.disp[7]}}, ins.disp};
    assign target  = taken ? 16'(chk_seq + chk_off) : chk_seq;

    always_comb begin
        s = q;
        if (s_axi_awvalid && s_axi_awready) begin
            s.aw_got = 1'b1;
            s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s.w_got = 1'b1;
            s.wdata = s_axi_wdata;
            s.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            s.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            s.rvalid = 1'b0;
        end

        // Write decode; operand registers are frozen while an instruction runs
        if (do_wr) begin
            s.aw_got = 1'b0;
            s.w_got  = 1'b0;
            s.bvalid = 1'b1;
            s.bresp  = BBCE_RESP_OKAY;
            if (q.awaddr == BBCE_OFF_INSN) begin
                if (q.st == ST_IDLE) begin
                    s.insn = 24'(bbce_merge({8'h00, q.insn}, q.wdata, q.wstrb))
                             & BBCE_INSN_MASK;
                end
            end else if (q.awaddr == BBCE_OFF_PC) begin
                if (q.st == ST_IDLE) begin
                    s.pc = 16'(bbce_merge({16'h0000, q.pc}, q.wdata, q.wstrb));
                end
            end else if (q.awaddr == BBCE_OFF_DATA) begin
                if (q.st == ST_IDLE) begin
                    s.opnd = 8'(bbce_merge({24'h000000, q.opnd}, q.wdata, q.wstrb));
                    s.program_status_word  = 8'(bbce_merge({16'h0000, q.program_status_word, 8'h00}, q.wdata, q.wstrb) >> 8);
                end
            end else if (q.awaddr == BBCE_OFF_CLKSEL) begin
                if (q.wstrb[0]) begin
                    s.clksel = q.wdata[2:0];
                end
            end else if (q.awaddr == BBCE_OFF_CMD) begin
                if (q.wstrb[0] && q.wdata[BBCE_CMD_WAKE]) begin
                    s.halt = 1'b0;
                    s.stop = 1'b0;
                end
                if (q.wstrb[0] && q.wdata[BBCE_CMD_START]) begin
                    s.err  = !start;
                    s.done = 1'b0;
                end
            end else if (q.awaddr != BBCE_OFF_STATUS) begin
                s.bresp = BBCE_RESP_SLVERR;
            end
        end

        if (start) begin
            s.st        = ST_RUN;
            s.cnt       = cost.cyc;
            s.chk_ticks = 5'h00;
        end else if (q.st == ST_RUN && tick) begin
            s.cnt       = 5'(q.cnt - 5'h01);
            s.chk_ticks = 5'(q.chk_ticks + 5'h01);
        end

        // All effects land together in the last cycle, so nothing sees a half update
        if (commit) begin
            s.st    = ST_IDLE;
            s.done  = 1'b1;
            s.taken = taken;
            s.pc    = target;
            s.opnd  = new_opnd;
            s.program_status_word   = new_psw;
            if (ins.op == OP_UNMASK) begin
                s.ie = 1'b1;
            end else if (ins.op == OP_MASK) begin
                s.ie = 1'b0;
            end else if (ins.op == OP_HALT) begin
                s.halt = 1'b1;
            end else if (ins.op == OP_STOP) begin
                s.stop = 1'b1;
            end
        end

        if (s_axi_arvalid && s_axi_arready) begin
            s.rvalid = 1'b1;
            s.rresp  = BBCE_RESP_OKAY;
            if (s_axi_araddr == BBCE_OFF_INSN) begin
                s.rdata = {8'h00, q.insn};
            end else if (s_axi_araddr == BBCE_OFF_PC) begin
                s.rdata = {16'h0000, q.pc};
            end else if (s_axi_araddr == BBCE_OFF_DATA) begin
                s.rdata = {16'h0000, q.program_status_word, q.opnd};
            end else if (s_axi_araddr == BBCE_OFF_CLKSEL) begin
                s.rdata = {29'h00000000, q.clksel};
            end else if (s_axi_araddr == BBCE_OFF_CMD) begin
                s.rdata = 32'h00000000;
            end else if (s_axi_araddr == BBCE_OFF_STATUS) begin
                s.rdata = status;
            end else begin
                s.rdata = 32'h00000000;
                s.rresp = BBCE_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q        <= '0;
            q.pc     <= BBCE_PC_RST;
            q.opnd   <= BBCE_BYTE_RST;
            q.program_status_word    <= BBCE_BYTE_RST;
            q.clksel <= BBCE_CLKSEL_RST;
            q.st     <= ST_IDLE;
        end else begin
            q <= s;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_fall_through;
        commit && !taken |=> q.pc == $past(chk_seq);
    endproperty
    a_fall_through: assert property (p_fall_through) else $error("next pc wrong");

    property p_jump_target;
        commit && taken |=> q.pc == 16'($past(chk_seq) + $past(chk_off));
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_cycle_count;
        commit |-> 5'(q.chk_ticks + 5'h01) == cost.cyc;
    endproperty
    a_cycle_count: assert property (p_cycle_count) else $error("cycle count wrong");

    property p_unmask;
        commit && ins.op == OP_UNMASK |=> q.ie && irq_accept_ok;
    endproperty
    a_unmask: assert property (p_unmask) else $error("allow flag not set");

    property p_mask;
        commit && ins.op == OP_MASK |=> !q.ie [*2];
    endproperty
    a_mask: assert property (p_mask) else $error("allow flag not cleared");

    property p_tclr_clears;
        commit && ins.op == OP_BIT_TCLR && bit_val && ins.mode != MD_PSW
        |=> !q.opnd[ins.bitn] && q.taken;
    endproperty
    a_tclr_clears: assert property (p_tclr_clears) else $error("bit not cleared");

    property p_clear_sense;
        commit && ins.op == OP_BIT_CLEAR |=> q.taken == !$past(bit_val);
    endproperty
    a_clear_sense: assert property (p_clear_sense) else $error("clear test inverted");

    property p_dec_loop;
        commit && ins.op == OP_DEC_BNZ |=> q.opnd == 8'($past(q.opnd) - 8'h01)
                                           && q.taken == (q.opnd != 8'h00);
    endproperty
    a_dec_loop: assert property (p_dec_loop) else $error("loop decrement wrong");

    property p_standby_stall;
        (q.halt || q.stop) |-> !tick;
    endproperty
    a_standby_stall: assert property (p_standby_stall) else $error("tick while halted");

    property p_atomic_hold;
        q.st == ST_RUN && $past(q.st) == ST_RUN |-> $stable(q.insn) && $stable(q.opnd)
                                                   && $stable(q.program_status_word);
    endproperty
    a_atomic_hold: assert property (p_atomic_hold) else $error("operands moved");

    c_tclr_jump: cover property (commit && ins.op == OP_BIT_TCLR && taken);
    c_loop_exit: cover property (commit && ins.op == OP_DEC_BNZ && !taken);
    c_unmask:    cover property (commit && ins.op == OP_UNMASK);
    c_halted:    cover property (commit && ins.op == OP_HALT ##1 q.halt);
endmodule
`default_nettype wire

/* bench/bbce_exec_top_tb_top.sv */
// Random self-checking bench of the bit-branch execution unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module bbce_exec_top_tb_top
    import bbce_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        arv = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] seed = 32'h2C;
    logic [31:0] v;
    logic [31:0] rdat;
    logic [1:0]  rsp;
    logic [1:0]  br;
    logic [1:0]  rr;
    logic        awr, wrd, bv, arr, rv, tick, irq_ok, halted, stopped;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n_tick = 0;
    int          k;

    bbce_exec_top i_bbce_exec_top (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .cpu_tick(tick), .irq_accept_ok(irq_ok), .core_halted(halted), .osc_stopped(stopped));

    always #5 core_clk = ~core_clk;

    // About 50 instructions at under a hundred cycles each
    always @(posedge core_clk) begin
        cyc++;
        if (tick)
            n_tick++;
        if (cyc > 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Length and both cycle columns; zero marks a missing column
    function automatic logic [7:0] cost(logic [5:0] om, logic ea, logic ef);
        logic [12:0] r;
        logic [4:0]  c;
        case (om)
            6'h00: r = {3'h3, 5'h08, 5'h09};
            6'h01, 6'h09: r = {3'h4, 5'h00, 5'h0B};
            6'h02, 6'h0A, 6'h12: r = {3'h3, 5'h08, 5'h00};
            6'h03: r = {3'h3, 5'h00, 5'h09};
            6'h04, 6'h0C: r = {3'h3, 5'h0A, 5'h0B};
            6'h08: r = {3'h4, 5'h0A, 5'h0B};
            6'h0B: r = {3'h4, 5'h00, 5'h0B};
            6'h10: r = {3'h4, 5'h0A, 5'h0C};
            6'h11, 6'h13: r = {3'h4, 5'h00, 5'h0C};
            6'h14: r = {3'h3, 5'h0A, 5'h0C};
            6'h18: r = {3'h3, 5'h08, 5'h0A};
            default: r = {3'h2, 5'h06, 5'h00};
        endcase
        c = ea ? (r[4:0] != 5'h00 ? r[4:0] : r[9:5]) : (r[9:5] != 5'h00 ? r[9:5] : r[4:0]);
        return {r[12:10], 5'(c + (ef ? 5'h02 : 5'h00))};
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic pa, pw, ha, hw;
        @(posedge core_clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge core_clk);
            ha = awr;
            hw = wrd;
            @(posedge core_clk);
            if (pa && ha) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (pw && hw) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(negedge core_clk); while (!bv);
        rsp = br;
        @(posedge core_clk);
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        ara <= a;
        arv <= 1'b1;
        do @(negedge core_clk); while (!arr);
        @(posedge core_clk);
        arv <= 1'b0;
        do @(negedge core_clk); while (!rv);
        v = rdat;
        rsp = rr;
        @(posedge core_clk);
    endtask

    // Ticks seen over n whole clock cycles, negedge to negedge
    task automatic count_ticks(int n);
        @(negedge core_clk);
        k = n_tick;
        repeat (n) @(negedge core_clk);
        k = n_tick - k;
    endtask

    task automatic exec(logic [31:0] insn);
        wr(BBCE_OFF_INSN, insn);
        wr(BBCE_OFF_CMD, 32'h1);
        do rd(BBCE_OFF_STATUS); while (!v[1] && !v[6]);
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        logic [2:0]  op, md, bn;
        logic [7:0]  dp, by, ps, src, ce;
        logic [15:0] pc, dx;
        logic        ea, ef, tk, ie;
        ie = 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h18);
        `CHK({rsp, v}, {BBCE_RESP_SLVERR, 32'h0})
        wr(8'h18, 32'h0);
        `CHK(rsp, BBCE_RESP_SLVERR)
        rd(BBCE_OFF_PC);
        `CHK(v, 32'h0)
        exec(32'h50);
        `CHK(v[6], 1'b1)
        for (int i = 0; i < 48; i++) begin
            op = 3'(rnd() % 6);
            md = op == 3'h3 ? (rnd() % 3 == 0 ? 3'h0 : 3'(5 + rnd() % 2))
                            : (op > 3'h3 ? 3'h0 : 3'(rnd() % 5));
            bn = 3'(rnd());
            dp = i == 0 ? 8'h80 : (i == 1 ? 8'h7F : 8'(rnd()));
            by = 8'(rnd());
            ps = 8'(rnd());
            pc = 16'(rnd());
            ea = 1'(rnd());
            ef = 1'(rnd());
            // Loop counter reaching zero must fall through
            if (i == 2) begin
                op = 3'h3;
                md = 3'h5;
                by = 8'h01;
            end
            wr(BBCE_OFF_CLKSEL, rnd() % 3);
            wr(BBCE_OFF_DATA, {16'h0, ps, by});
            wr(BBCE_OFF_PC, {16'h0, pc});
            exec({8'h00, dp, 4'h0, ef, ea, bn, md, 1'b0, op});
            src = md == 3'h3 ? ps : by;
            tk = op == 3'h0 || op == 3'h2 ? src[bn] : (op == 3'h1 ? !src[bn] :
                 op == 3'h3 && 8'(by - 8'h01) != 8'h00);
            dx = {ps, by};
            if (op == 3'h2 && tk)
                dx[md == 3'h3 ? 4'(bn) + 4'h8 : 4'(bn)] = 1'b0;
            if (op == 3'h3)
                dx[7:0] = by - 8'h01;
            if (op == 3'h4)
                ie = 1'b1;
            if (op == 3'h5)
                ie = 1'b0;
            ce = cost({op, md}, ea, ef);
            `CHK(v[10:8], ce[7:5])
            `CHK(v[20:16], ce[4:0])
            `CHK({v[3:2], irq_ok}, {ie, tk, ie})
            rd(BBCE_OFF_PC);
            `CHK(v[15:0], pc + ce[7:5] + (tk ? {{8{dp[7]}}, dp} : 16'h0))
            rd(BBCE_OFF_DATA);
            `CHK(v[15:0], dx)
        end
        for (int h = 6; h < 8; h++) begin
            exec(32'(h));
            `CHK(h == 6 ? halted : stopped, 1'b1)
            count_ticks(8);
            `CHK(k, 0)
            exec(32'h0);
            `CHK(v[6], 1'b1)
            wr(BBCE_OFF_CMD, 32'h2);
            `CHK(halted | stopped, 1'b0)
            `CHK(rsp, BBCE_RESP_OKAY)
        end
        wr(BBCE_OFF_CLKSEL, 32'h2);
        count_ticks(16);
        `CHK(k, 4)
        stop_test();
    end
endmodule
`default_nettype wire
